//--- ccms_pkg.sv
package ccms_pkg;

	// ---------------------------------------------------------------
	// widths
	// ---------------------------------------------------------------
	localparam int unsigned CNT_W       = 16;
	localparam int unsigned TCL_W       = 8;
	localparam int unsigned TIME_W      = CNT_W + TCL_W;
	localparam int unsigned MODE_W      = 3;

	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int unsigned MODE_SEL_BIT = 2;
	localparam logic [CNT_W-1:0] CNT_ZERO = 16'h0000;
	localparam logic [CNT_W-1:0] CNT_MAX  = 16'hffff;
	localparam logic [CNT_W-1:0] CNT_ONE  = 16'h0001;
	localparam logic [TIME_W-1:0] TIME_ZERO = 24'h000000;

	// ---------------------------------------------------------------
	// timing counts
	// ---------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS  = 40;
	localparam int unsigned STALL_NS       = 40960;
	localparam int unsigned STALL_CYCLES   = STALL_NS / CLK_PERIOD_NS;
	localparam int unsigned EDGES_TO_RUN   = 3;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic {
		CCMS_DIRECT    = 1'b0,
		CCMS_PRESCALER = 1'b1
	} ccms_mode_t;

	typedef enum logic [1:0] {
		CCMS_ST_RESET = 2'b00,
		CCMS_ST_SYNC  = 2'b01,
		CCMS_ST_RUN   = 2'b11
	} ccms_state_t;

	typedef struct packed {
		logic [CNT_W-1:0] osc_period;
		logic [CNT_W-1:0] half_phase_min;
	} ccms_meas_t;

endpackage

//--- ccms_clock_mode_select.sv
// Contract
// RL1: top bit of clock_mode_field set: cpu clock is oscillator divided by two.
// RL2: divide-by-two mode: each cpu clock phase lasts one oscillator period.
// RL3: top bit clear: phase locked loop off, cpu clock straight from oscillator.
// RL4: direct mode: cpu clock frequency and duty cycle follow the oscillator.
// RL5: direct mode: two consecutive half-phases always sum to one oscillator period.
// RL6: odd half-phase counts include one minimum half-phase; even counts use periods.
// RL7: clock mode field is captured during reset and kept afterwards.
// RL8: mode never changes while running; only the next reset resamples it.
`timescale 1ns/1ns
`default_nettype none

module ccms_clock_mode_select #(
	parameter int unsigned STALL_CYCLES = ccms_pkg::STALL_CYCLES
) (
	// clock and reset
	input  wire logic                           clk,
	input  wire logic                           reset,
	// oscillator and configuration pins
	input  wire logic                           osc_in,
	input  wire logic [ccms_pkg::MODE_W-1:0]    clock_mode_field,
	// half-phase timing request
	input  wire logic [ccms_pkg::TCL_W-1:0]     tcl_count,
	// generated clock
	output logic                                cpu_clk,
	output logic                                cpu_clk_edge,
	output logic                                pll_enable,
	output ccms_pkg::ccms_mode_t                mode,
	output logic                                running,
	output logic                                osc_stalled,
	// measurements in clk cycles
	output ccms_pkg::ccms_meas_t                meas,
	output logic [ccms_pkg::TIME_W-1:0]         timing_cycles
);

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	logic                        osc_meta;
	logic                        osc_sync;
	logic                        osc_prev;
	logic [ccms_pkg::MODE_W-1:0] strap_meta;
	logic [ccms_pkg::MODE_W-1:0] strap_sync;
	logic                        osc_rise;
	logic                        osc_fall;
	logic                        osc_edge;

	always_ff @(posedge clk) begin
		osc_meta <= osc_in;
		osc_sync <= osc_meta;
		osc_prev <= osc_sync;
	end

	always_ff @(posedge clk) begin
		strap_meta <= clock_mode_field;
		strap_sync <= strap_meta;
	end

	assign osc_rise = osc_sync & ~osc_prev;
	assign osc_fall = ~osc_sync & osc_prev;
	assign osc_edge = osc_rise | osc_fall;

	// ---------------------------------------------------------------
	// mode capture
	// ---------------------------------------------------------------
	// sampled every cycle while reset is held, frozen afterwards
	always_ff @(posedge clk) begin
		if (reset) begin
			mode <= ccms_pkg::ccms_mode_t'(strap_sync[ccms_pkg::MODE_SEL_BIT]); // RL7
		end
	end // RL8

	always_ff @(posedge clk) begin
		if (reset) begin
			pll_enable <= 1'b0;
		end else begin
			pll_enable <= 1'b0; // RL3
		end
	end

	// ---------------------------------------------------------------
	// start-up sequencing
	// ---------------------------------------------------------------
	ccms_pkg::ccms_state_t state;
	logic [1:0]            edge_cnt;

	always_ff @(posedge clk) begin
		if (reset) begin
			state    <= ccms_pkg::CCMS_ST_RESET;
			edge_cnt <= 2'h0;
		end else begin
			unique case (state)
				ccms_pkg::CCMS_ST_RESET: begin
					state    <= ccms_pkg::CCMS_ST_SYNC;
					edge_cnt <= 2'h0;
				end
				ccms_pkg::CCMS_ST_SYNC: begin
					// let measurements settle before the clock is declared good
					if (osc_edge) begin
						if (edge_cnt == 2'(ccms_pkg::EDGES_TO_RUN - 1)) begin
							state <= ccms_pkg::CCMS_ST_RUN;
						end
						edge_cnt <= edge_cnt + 2'h1;
					end
				end
				ccms_pkg::CCMS_ST_RUN: begin
					if (osc_stalled) begin
						state    <= ccms_pkg::CCMS_ST_SYNC;
						edge_cnt <= 2'h0;
					end
				end
				default: begin
					state <= ccms_pkg::CCMS_ST_RESET;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			running <= 1'b0;
		end else begin
			running <= (state == ccms_pkg::CCMS_ST_RUN) && !osc_stalled;
		end
	end

	// ---------------------------------------------------------------
	// cpu clock generation
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			cpu_clk      <= 1'b0;
			cpu_clk_edge <= 1'b0;
		end else if (mode == ccms_pkg::CCMS_PRESCALER) begin
			// only rising edges: input duty cycle cannot shape the phases
			cpu_clk_edge <= osc_rise; // RL1
			if (osc_rise) begin
				cpu_clk <= ~cpu_clk; // RL2
			end
		end else begin
			cpu_clk      <= osc_sync; // RL4
			cpu_clk_edge <= osc_edge; // RL3
		end
	end

	// ---------------------------------------------------------------
	// oscillator stall watchdog
	// ---------------------------------------------------------------
	logic [ccms_pkg::CNT_W-1:0] stall_cnt;

	always_ff @(posedge clk) begin
		if (reset || osc_edge) begin
			stall_cnt   <= ccms_pkg::CNT_ZERO;
			osc_stalled <= 1'b0;
		end else if (stall_cnt == ccms_pkg::CNT_W'(STALL_CYCLES - 1)) begin
			osc_stalled <= 1'b1;
		end else begin
			stall_cnt <= stall_cnt + ccms_pkg::CNT_ONE;
		end
	end

	// ---------------------------------------------------------------
	// half-phase measurement
	// ---------------------------------------------------------------
	// counts saturate; a stopped oscillator must not wrap into a short value
	logic [ccms_pkg::CNT_W-1:0] half_cnt;
	logic [ccms_pkg::CNT_W-1:0] last_half;
	logic [ccms_pkg::CNT_W-1:0] this_half;
	logic [ccms_pkg::CNT_W:0]   pair_sum;
	logic                       have_half;
	logic [ccms_pkg::CNT_W-1:0] osc_period;
	logic [ccms_pkg::CNT_W-1:0] half_phase_min;

	// one process per field; the port is only wiring of these flops
	assign meas = {osc_period, half_phase_min};

	assign this_half = half_cnt + ccms_pkg::CNT_ONE;
	assign pair_sum  = {1'b0, last_half} + {1'b0, this_half};

	always_ff @(posedge clk) begin
		if (reset || osc_edge) begin
			half_cnt <= ccms_pkg::CNT_ZERO;
		end else if (half_cnt != ccms_pkg::CNT_MAX) begin
			half_cnt <= half_cnt + ccms_pkg::CNT_ONE;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			last_half <= ccms_pkg::CNT_ZERO;
			have_half <= 1'b0;
		end else if (osc_stalled) begin
			have_half <= 1'b0;
		end else if (osc_edge) begin
			last_half <= this_half;
			have_half <= 1'b1;
		end
	end

	// period from two consecutive half-phases cancels duty error
	always_ff @(posedge clk) begin
		if (reset) begin
			osc_period <= ccms_pkg::CNT_ZERO;
		end else if (osc_edge && have_half) begin
			osc_period <= pair_sum[ccms_pkg::CNT_W] ? ccms_pkg::CNT_MAX :
				pair_sum[ccms_pkg::CNT_W-1:0]; // RL5
		end
	end

	// shortest cpu half-phase seen since reset in direct mode; latest osc_period behind the prescaler
	always_ff @(posedge clk) begin
		if (reset) begin
			half_phase_min <= ccms_pkg::CNT_MAX;
		end else if (mode == ccms_pkg::CCMS_PRESCALER) begin
			if (osc_edge && have_half) begin
				half_phase_min <= osc_period; // RL2
			end
		end else if (osc_edge && (this_half < half_phase_min)) begin
			half_phase_min <= this_half; // RL4
		end
	end

	// ---------------------------------------------------------------
	// half-phase timing calculator
	// ---------------------------------------------------------------
	logic [ccms_pkg::TIME_W-1:0] even_part;
	logic [ccms_pkg::TIME_W-1:0] odd_part;
	logic [ccms_pkg::CNT_W:0]    cpu_period;

	// a pair of half-phases is one cpu period: two oscillator periods behind the prescaler
	assign cpu_period = (mode == ccms_pkg::CCMS_PRESCALER) ? {osc_period, 1'b0} :
		{1'b0, osc_period}; // RL2
	assign even_part = ccms_pkg::TIME_W'(tcl_count[ccms_pkg::TCL_W-1:1]) *
		ccms_pkg::TIME_W'(cpu_period);
	assign odd_part  = tcl_count[0] ? ccms_pkg::TIME_W'(half_phase_min) :
		ccms_pkg::TIME_ZERO;

	always_ff @(posedge clk) begin
		if (reset) begin
			timing_cycles <= ccms_pkg::TIME_ZERO;
		end else begin
			timing_cycles <= even_part + odd_part; // RL6
		end
	end

endmodule

`default_nettype wire

//--- ccms_end.sv
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

//--- ccms_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module ccms_assertions #(
	parameter int unsigned STALL_CYCLES = 16
) (
	input wire logic                         clk,
	input wire logic                         reset,
	input wire logic                         osc_in,
	input wire logic [ccms_pkg::TCL_W-1:0]   tcl_count,
	input wire logic                         cpu_clk,
	input wire logic                         cpu_clk_edge,
	input wire logic                         pll_enable,
	input wire ccms_pkg::ccms_mode_t         mode,
	input wire logic                         running,
	input wire ccms_pkg::ccms_meas_t         meas,
	input wire logic [ccms_pkg::TIME_W-1:0]  timing_cycles
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	wire logic ps = (mode == ccms_pkg::CCMS_PRESCALER);

	a_pll_off: assert property (pll_enable == 1'b0)
		else $error("pll enabled");
	a_mode_kept: assert property (!$past(reset) |-> $stable(mode))
		else $error("mode changed while running");
	a_edge_toggles: assert property (cpu_clk_edge |-> cpu_clk != $past(cpu_clk))
		else $error("edge flag without cpu clock change");
	a_clk_quiet: assert property (!cpu_clk_edge && !$past(reset) |-> $stable(cpu_clk))
		else $error("cpu clock changed without edge flag");
	a_edge_single: assert property (cpu_clk_edge |=> !cpu_clk_edge)
		else $error("edge flag longer than one cycle");
	a_ps_rise: assert property (ps && running && $rose(osc_in) |-> ##[2:4] cpu_clk_edge)
		else $error("prescaler missed oscillator rise");
	a_ps_fall: assert property (ps && running && $fell(osc_in) |-> ##1 !cpu_clk_edge [*4])
		else $error("prescaler toggled on oscillator fall");
	a_dd_edge: assert property (!ps && running && $changed(osc_in) |-> ##[2:4] cpu_clk_edge)
		else $error("direct mode missed oscillator edge");
	a_dd_follow: assert property ((!ps && running && $stable(osc_in)) [*6] |-> cpu_clk == osc_in)
		else $error("direct mode cpu clock differs from oscillator");
	a_tcl_calc: assert property (!$past(reset) |-> timing_cycles ==
		($past(tcl_count) >> 1) * (ps ? 24'h000002 : 24'h000001) * $past(meas.osc_period)
		+ ($past(tcl_count[0]) ? $past(meas.half_phase_min) : 16'h0000))
		else $error("half-phase timing wrong");

	c_ps_edge: cover property (ps && cpu_clk_edge);
	c_dd_edge: cover property (!ps && cpu_clk_edge);
	c_odd_tcl: cover property (!ps && tcl_count[0] && running);
endmodule
`default_nettype wire

//--- ccms_osc_model.sv
`timescale 1ns/1ns
`default_nettype none
module ccms_osc_model (
	input wire logic en,
	input var int    hi,
	input var int    lo,
	output logic     osc
);
	// stands low between runs; odd offset keeps edges off the clk edge
	always begin
		if (!en) begin
			osc = 1'b0;
			wait (en);
			#13;
		end
		#(lo * 40) osc = 1'b1;
		#(hi * 40) osc = 1'b0;
	end
endmodule
`default_nettype wire

//--- ccms_clock_mode_select_test.sv
`timescale 1ns/1ns
`default_nettype none
module ccms_clock_mode_select_test;
	logic                         clk = 1'b0;
	logic                         reset = 1'b1;
	logic [2:0]                   clock_mode_field = 3'h0;
	logic [7:0]                   tcl_count = 8'h00;
	logic                         osc_en = 1'b0;
	int                           hi = 5;
	int                           lo = 6;
	int                           seed = 32'h08b4;
	int                           n_errors = 0;
	int                           comparisons = 0;
	logic                         osc_in;
	logic                         cpu_clk, cpu_clk_edge, pll_enable, running, osc_stalled;
	ccms_pkg::ccms_mode_t         mode;
	ccms_pkg::ccms_meas_t         meas;
	logic [23:0]                  timing_cycles;

	always #20 clk = ~clk;
	ccms_osc_model u_osc (.en(osc_en), .hi(hi), .lo(lo), .osc(osc_in));
	ccms_clock_mode_select #(.STALL_CYCLES(16)) u_dut (.clk(clk), .reset(reset),
		.osc_in(osc_in), .clock_mode_field(clock_mode_field), .tcl_count(tcl_count),
		.cpu_clk(cpu_clk), .cpu_clk_edge(cpu_clk_edge), .pll_enable(pll_enable),
		.mode(mode), .running(running), .osc_stalled(osc_stalled), .meas(meas),
		.timing_cycles(timing_cycles));

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %0t got %0h expected %0h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		if (n_errors == 0 && comparisons > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// cycles high and whole period of cpu_clk, from one rise
	task automatic meas_clk(output int h, output int p);
		int n;
		n = 0;
		while (cpu_clk !== 1'b0 && n < 400) begin @(negedge clk); n++; end
		while (cpu_clk !== 1'b1 && n < 400) begin @(negedge clk); n++; end
		h = 0;
		while (cpu_clk === 1'b1 && n < 400) begin @(negedge clk); n++; h++; end
		p = h;
		while (cpu_clk === 1'b0 && n < 400) begin @(negedge clk); n++; p++; end
	endtask

	initial begin
		repeat (30000) @(posedge clk);
		n_errors++;
		finish_test;
	end

	initial begin
		int h, p, e, t;
		repeat (2) @(posedge clk);
		for (int c = 0; c < 8; c++) begin
			hi = 5 + c % 3;
			lo = 6 + c % 2;
			@(posedge clk);
			reset <= 1'b1;
			clock_mode_field <= c[2:0];
			repeat (4) @(posedge clk);
			reset <= 1'b0;
			osc_en <= 1'b1;
			e = 0;
			while (running !== 1'b1 && e < 500) begin @(negedge clk); e++; end
			chk(running, 1);
			@(posedge clk);
			clock_mode_field <= ~c[2:0];
			chk(mode, c[2]);
			chk(pll_enable, 0);
			meas_clk(h, p);
			chk(h, c[2] ? hi + lo : hi);
			chk(p, c[2] ? 2 * (hi + lo) : hi + lo);
			chk(meas.osc_period, hi + lo);
			chk(meas.half_phase_min, c[2] ? hi + lo : (hi < lo ? hi : lo));
			chk(mode, c[2]);
			for (int k = 0; k < 4; k++) begin
				@(posedge clk);
				t = $random(seed) & 255;
				tcl_count <= t[7:0];
				repeat (2) @(negedge clk);
				e = (t >> 1) * (hi + lo) + ((t & 1) ? (hi < lo ? hi : lo) : 0);
				if (c[2])
					e = t * (hi + lo);
				chk(timing_cycles, e);
			end
			@(posedge clk);
			osc_en <= 1'b0;
			e = 0;
			while (osc_stalled !== 1'b1 && e < 80) begin @(negedge clk); e++; end
			chk(osc_stalled, 1);
			@(negedge clk);
			chk(running, 0);
		end
		finish_test;
	end
endmodule

bind ccms_clock_mode_select ccms_assertions #(.STALL_CYCLES(STALL_CYCLES)) u_chk (
	.clk(clk), .reset(reset), .osc_in(osc_in), .tcl_count(tcl_count),
	.cpu_clk(cpu_clk), .cpu_clk_edge(cpu_clk_edge), .pll_enable(pll_enable),
	.mode(mode), .running(running), .meas(meas), .timing_cycles(timing_cycles));
`default_nettype wire
